// ===== design/aisc_top.sv
// Masked interrupt status and clear logic for the four sample sequencers
`timescale 1ns/1ps
module aisc_top
  import aisc_pkg::*;
#(
  parameter int NSEQ = AISC_NSEQ,
  parameter int NSTEP = AISC_NSTEP
) (
  input wire logic hclk,                              // Clock, 10 MHz
  input wire logic hresetn,                           // Async reset, active low
  input wire logic hsel,                              // AHB select
  input wire logic [31:0] haddr,                      // AHB address
  input wire logic [1:0] htrans,                      // AHB transfer type
  input wire logic hwrite,                            // AHB write
  input wire logic [2:0] hsize,                       // AHB size
  input wire logic [31:0] hwdata,                     // AHB write data
  input wire logic hready,                            // AHB ready in
  output logic hreadyout,                             // AHB ready out
  output logic [31:0] hrdata,                         // AHB read data
  output logic hresp,                                 // AHB response
  input wire logic [NSEQ-1:0] sample_done,            // Sample converted, per sequencer
  input wire logic [NSEQ*AISC_STEP_W-1:0] sample_step, // Step index of that sample
  input wire logic cmp_event,                         // Comparator interrupt event
  output logic [NSEQ-1:0] seq_irq,                    // Level lines to the processor
  output logic irq                                    // Any line active
);

  aisc_bus_req_t req;
  logic [31:0] rdata;

  logic [NSEQ-1:0] mask_ff;
  logic [NSEQ-1:0] nxt_mask;
  logic [NSEQ-1:0] route_ff;
  logic [NSEQ-1:0] nxt_route;
  logic [31:0] stepen_ff;
  logic [31:0] nxt_stepen;

  logic [NSEQ-1:0] raw_sequencer_flag;
  logic raw_comparator_flag;
  logic [NSEQ-1:0] seq_set;
  logic [NSEQ-1:0] seq_clr;
  logic cmp_clr;
  logic route_single;
  logic [NSEQ-1:0] sequencer_masked_status;
  logic [NSEQ-1:0] comparator_masked_status;

  aisc_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .req(req),
    .rdata(rdata)
  );

  // Raw sequencer flag sets on a completed sample whose step enable is on
  always_comb begin
    for (int i = 0; i < NSEQ; i++) begin
      seq_set[i] = sample_done[i] &
        stepen_ff[i*NSTEP + int'(sample_step[i*AISC_STEP_W +: AISC_STEP_W])];
    end
  end

  // Clear by one regardless of the masked value
  assign seq_clr = (req.wr && req.addr == AISC_OFF_ISC) ?
    req.wdata[AISC_SEQ_LSB +: NSEQ] : '0;
  // Comparator bits of this register are not write targets
  assign cmp_clr = req.wr && (req.addr == AISC_OFF_DCCLR) &&
    req.wdata[AISC_DCCLR_BIT];

  aisc_sticky #(
    .W(NSEQ)
  ) u_seq_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(seq_set),
    .clr(seq_clr),
    .q(raw_sequencer_flag)
  );

  aisc_sticky #(
    .W(1)
  ) u_cmp_flag (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(cmp_event),
    .clr(cmp_clr),
    .q(raw_comparator_flag)
  );

  // Mask, routing and step enable registers
  always_comb begin
    nxt_mask = mask_ff;
    nxt_route = route_ff;
    nxt_stepen = stepen_ff;
    if (req.wr && req.addr == AISC_OFF_MASK) begin
      nxt_mask = req.wdata[AISC_SEQ_LSB +: NSEQ];
      nxt_route = req.wdata[AISC_CMP_LSB +: NSEQ];
    end
    if (req.wr && req.addr == AISC_OFF_STEPEN) begin
      nxt_stepen = req.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= AISC_MASK_RST;
      route_ff <= AISC_ROUTE_RST;
      stepen_ff <= AISC_STEPEN_RST;
    end else begin
      mask_ff <= nxt_mask;
      route_ff <= nxt_route;
      stepen_ff <= nxt_stepen;
    end
  end

  // More than one route bit masks the comparator flag on every line
  assign route_single = ((route_ff & (route_ff - 4'h1)) == 4'h0);

  assign sequencer_masked_status = raw_sequencer_flag & mask_ff;
  assign comparator_masked_status = (raw_comparator_flag && route_single) ?
    route_ff : '0;

  assign seq_irq = sequencer_masked_status | comparator_masked_status;
  assign irq = |seq_irq;

  // Read mux; unused and reserved bits read as zero
  always_comb begin
    rdata = 32'h00000000;
    case (req.addr)
      AISC_OFF_RAW: begin
        rdata[AISC_SEQ_LSB +: NSEQ] = raw_sequencer_flag;
        rdata[AISC_CMP_LSB] = raw_comparator_flag;
      end
      AISC_OFF_MASK: begin
        rdata[AISC_SEQ_LSB +: NSEQ] = mask_ff;
        rdata[AISC_CMP_LSB +: NSEQ] = route_ff;
      end
      AISC_OFF_ISC: begin
        rdata[AISC_SEQ_LSB +: NSEQ] = sequencer_masked_status;
        rdata[AISC_CMP_LSB +: NSEQ] = comparator_masked_status;
      end
      AISC_OFF_STEPEN: begin
        rdata = stepen_ff;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

endmodule : aisc_top

// ===== design/aisc_pkg.sv
// Package for the converter masked interrupt status and clear block
package aisc_pkg;

  localparam int AISC_NSEQ = 4;
  localparam int AISC_NSTEP = 8;
  localparam int AISC_STEP_W = 3;
  localparam int AISC_ADDR_W = 12;

  // Register byte offsets
  localparam logic [AISC_ADDR_W-1:0] AISC_OFF_RAW = 12'h004;
  localparam logic [AISC_ADDR_W-1:0] AISC_OFF_MASK = 12'h008;
  localparam logic [AISC_ADDR_W-1:0] AISC_OFF_ISC = 12'h00c;
  localparam logic [AISC_ADDR_W-1:0] AISC_OFF_DCCLR = 12'h034;
  localparam logic [AISC_ADDR_W-1:0] AISC_OFF_STEPEN = 12'h044;

  // Field positions
  localparam int AISC_SEQ_LSB = 0;
  localparam int AISC_CMP_LSB = 16;
  localparam int AISC_DCCLR_BIT = 0;

  // Reset values
  localparam logic [AISC_NSEQ-1:0] AISC_MASK_RST = 4'h0;
  localparam logic [AISC_NSEQ-1:0] AISC_ROUTE_RST = 4'h0;
  localparam logic [31:0] AISC_STEPEN_RST = 32'h00000000;
  localparam logic AISC_FLAG_RST = 1'b0;

  localparam logic [2:0] AISC_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AISC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } aisc_bus_req_t;

  typedef enum logic [1:0] {AISC_ST_IDLE, AISC_ST_ACCESS, AISC_ST_RESP} aisc_bus_st_t;

endpackage : aisc_pkg

// ===== design/aisc_sticky.sv
// Sticky flag bank: a set in the same cycle as a clear wins
`timescale 1ns/1ps
module aisc_sticky
  import aisc_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic hclk,            // Clock
  input wire logic hresetn,         // Async reset, active low
  input wire logic [W-1:0] set,     // Set pulses
  input wire logic [W-1:0] clr,     // Clear pulses
  output logic [W-1:0] q            // Flag levels
);

  logic [W-1:0] flag_ff;
  logic [W-1:0] nxt_flag;

  always_comb begin
    nxt_flag = set | (flag_ff & ~clr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= {W{AISC_FLAG_RST}};
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign q = flag_ff;

endmodule : aisc_sticky

// ===== design/aisc_ahb_slave.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
module aisc_ahb_slave
  import aisc_pkg::*;
(
  input wire logic hclk,                  // Clock
  input wire logic hresetn,               // Async reset, active low
  input wire logic hsel,                  // Slave select
  input wire logic [31:0] haddr,          // Address
  input wire logic [1:0] htrans,          // Transfer type
  input wire logic hwrite,                // Write when high
  input wire logic [2:0] hsize,           // Transfer size
  input wire logic [31:0] hwdata,         // Write data
  input wire logic hready,                // Bus ready
  output logic hreadyout,                 // Slave ready
  output logic [31:0] hrdata,             // Read data
  output logic hresp,                     // Response, always OKAY
  output aisc_bus_req_t req,              // Register access strobe
  input wire logic [31:0] rdata           // Register read value
);

  aisc_bus_st_t st_ff;
  aisc_bus_st_t nxt_st;
  logic [AISC_ADDR_W-1:0] addr_ff;
  logic [AISC_ADDR_W-1:0] nxt_addr;
  logic wr_ff;
  logic nxt_wr;
  logic ok_ff;
  logic nxt_ok;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic take;

  assign take = hsel & htrans[1] & hready;

  always_comb begin
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_wr = wr_ff;
    nxt_ok = ok_ff;
    nxt_rdata = rdata_ff;
    case (st_ff)
      AISC_ST_IDLE, AISC_ST_RESP: begin
        if (take) begin
          nxt_st = AISC_ST_ACCESS;
          nxt_addr = haddr[AISC_ADDR_W-1:0];
          nxt_wr = hwrite;
          // Only aligned whole words reach the registers
          nxt_ok = (hsize == AISC_HSIZE_WORD) && (haddr[1:0] == 2'h0);
        end else begin
          nxt_st = AISC_ST_IDLE;
        end
      end
      AISC_ST_ACCESS: begin
        nxt_st = AISC_ST_RESP;
        nxt_rdata = (!wr_ff && ok_ff) ? rdata : 32'h00000000;
      end
      default: begin
        nxt_st = AISC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= AISC_ST_IDLE;
      addr_ff <= '0;
      wr_ff <= 1'b0;
      ok_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      ok_ff <= nxt_ok;
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    req.wr = (st_ff == AISC_ST_ACCESS) && wr_ff && ok_ff;
    req.rd = (st_ff == AISC_ST_ACCESS) && !wr_ff && ok_ff;
    req.addr = addr_ff;
    req.wdata = hwdata;
  end

  assign hreadyout = (st_ff != AISC_ST_ACCESS);
  assign hrdata = rdata_ff;
  assign hresp = 1'b0;

endmodule : aisc_ahb_slave

// ===== bench/aisc_src_model.sv
// Sample and comparator event source facing the interrupt block
`timescale 1ns/1ps
module aisc_src_model
  import aisc_pkg::*;
(
  input wire logic hclk, // Clock
  output logic [AISC_NSEQ-1:0] sample_done, // Sample pulses
  output logic [AISC_NSEQ*AISC_STEP_W-1:0] sample_step, // Step indexes
  output logic cmp_event // Comparator pulse
);
  initial begin
    sample_done = '0;
    sample_step = '0;
    cmp_event = 1'b0;
  end
  // Step lines are scrambled outside the pulse
  task automatic sample(input int i, input logic [2:0] s);
    @(posedge hclk);
    sample_done[i] <= 1'b1;
    sample_step[3*i+:3] <= s;
    @(posedge hclk);
    sample_done <= '0;
    sample_step <= ~sample_step;
  endtask : sample
  task automatic compare;
    @(posedge hclk);
    cmp_event <= 1'b1;
    @(posedge hclk);
    cmp_event <= 1'b0;
  endtask : compare
endmodule : aisc_src_model

// ===== bench/aisc_top_properties.sv
// Port assertions for the interrupt status block
`timescale 1ns/1ps
module aisc_top_properties
  import aisc_pkg::*;
#(
  parameter int NSEQ = 4
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic [31:0] hrdata, // Read data
  input wire logic hresp, // Response
  input wire logic [NSEQ-1:0] sample_done, // Samples
  input wire logic cmp_event, // Comparator
  input wire logic [NSEQ-1:0] seq_irq, // Lines
  input wire logic irq // Any line
);
  logic rd_ff;
  logic rd2_ff;
  logic wr_ff;
  wire logic go = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= 1'b0;
      rd2_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      rd_ff <= go & !hwrite & (haddr[AISC_ADDR_W-1:0] == AISC_OFF_ISC);
      rd2_ff <= rd_ff;
      wr_ff <= go & hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  one_wait_a: assert property (go |=> wait_s) else $error("wait state wrong");
  irq_any_a: assert property (irq == |seq_irq) else $error("irq not OR");
  resp_ok_a: assert property (hresp == 1'b0) else $error("resp not OKAY");
  rd_resv_a: assert property (rd2_ff |-> hrdata[31:20] == 12'h000 &&
    hrdata[15:4] == 12'h000) else $error("reserved bits set");
  rd_bits_a: assert property (rd2_ff |-> (hrdata[3:0] | hrdata[19:16]) ==
    $past(seq_irq)) else $error("status not lines");
  seq_cause_a: assert property ((seq_irq & ~$past(seq_irq)) != '0 |->
    $past(|sample_done | cmp_event | wr_ff)) else $error("line rose alone");
  seq_drop_a: assert property ((~seq_irq & $past(seq_irq)) != '0 |->
    $past(wr_ff)) else $error("line fell alone");
  rst_idle_a: assert property ($rose(hresetn) |-> seq_irq == '0 && hreadyout)
    else $error("reset state wrong");
endmodule : aisc_top_properties
bind aisc_top aisc_top_properties #(.NSEQ(NSEQ)) u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_done(sample_done),
  .cmp_event(cmp_event), .seq_irq(seq_irq), .irq(irq));

// ===== bench/tb_adc_interrupt_status_clear.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
module tb_adc_interrupt_status_clear;
  import aisc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, irq, cmp_event;
  logic [3:0] sample_done, seq_irq;
  logic [11:0] sample_step;
  int failures = 0, num_checks = 0, cycles = 0;
  aisc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(AISC_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_done(sample_done),
    .sample_step(sample_step), .cmp_event(cmp_event), .seq_irq(seq_irq), .irq(irq));
  aisc_src_model src (.hclk(hclk), .sample_done(sample_done), .sample_step(sample_step),
    .cmp_event(cmp_event));
  initial begin
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, '0);
    chk(q, exp);
  endtask : rd
  task automatic t_regs;
    rd(AISC_OFF_ISC, 32'h0);
    xfer(1'b1, AISC_OFF_MASK, 32'hffffffff);
    rd(AISC_OFF_MASK, 32'h000f000f);
    rd(12'h100, 32'h0);
    xfer(1'b1, AISC_OFF_MASK, 32'hf);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_seq;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, AISC_OFF_STEPEN, 32'h1 << (9 * i + 3));
      src.sample(i, 3'(i + 2));
      rd(AISC_OFF_RAW, 32'h0);
      src.sample(i, 3'(i + 3));
      #1 chk({irq, seq_irq}, {1'b1, 4'h1 << i});
      rd(AISC_OFF_ISC, 32'h1 << i);
      xfer(1'b1, AISC_OFF_ISC, 32'h1 << i);
      chk({irq, seq_irq}, 32'h0);
      rd(AISC_OFF_RAW, 32'h0);
    end
    $display("t_seq done");
  endtask : t_seq
  task automatic t_poll;
    xfer(1'b1, AISC_OFF_MASK, 32'h0);
    xfer(1'b1, AISC_OFF_STEPEN, 32'h00200000);
    src.sample(2, 3'd5);
    rd(AISC_OFF_ISC, 32'h0);
    chk({irq, seq_irq}, 32'h0);
    xfer(1'b1, AISC_OFF_ISC, 32'h0);
    rd(AISC_OFF_RAW, 32'h4);
    xfer(1'b1, AISC_OFF_ISC, 32'h4);
    rd(AISC_OFF_RAW, 32'h0);
    $display("t_poll done");
  endtask : t_poll
  task automatic t_cmp;
    for (int j = 0; j < 4; j++) begin
      xfer(1'b1, AISC_OFF_MASK, 32'h10000 << j);
      src.compare();
      #1 chk(seq_irq, 32'h1 << j);
      xfer(1'b1, AISC_OFF_ISC, 32'hffffffff);
      rd(AISC_OFF_ISC, 32'h10000 << j);
      xfer(1'b1, AISC_OFF_DCCLR, 32'h1);
      rd(AISC_OFF_ISC, 32'h0);
    end
    xfer(1'b1, AISC_OFF_MASK, 32'h30000);
    src.compare();
    rd(AISC_OFF_ISC, 32'h0);
    chk(seq_irq, 32'h0);
    rd(AISC_OFF_RAW, 32'h1 << AISC_CMP_LSB);
    $display("t_cmp done");
  endtask : t_cmp
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_seq();
    t_poll();
    t_cmp();
    summarize();
  end
endmodule : tb_adc_interrupt_status_clear
